/* design/plsr_cfg.svh */
`ifndef PLSR_CFG_SVH
`define PLSR_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLSR_A_CTRL 8'h00
`define PLSR_A_SUB 8'h04
`define PLSR_A_DEC1 8'h08
`define PLSR_A_DEC2 8'h0C
`define PLSR_A_SWF 8'h10
`define PLSR_A_REFF 8'h14
`define PLSR_A_COAST 8'h18
`define PLSR_A_UVG 8'h1C
`define PLSR_A_RCNT 8'h20
`define PLSR_A_RWAIT 8'h24
`define PLSR_A_RSEL 8'h28
`define PLSR_A_SUCC 8'h2C
`define PLSR_A_TERM0 8'h30
`define PLSR_A_STAT 8'h50
`define PLSR_A_FREQ 8'h54
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLSR_CTRL_REGEN_LSB 8
`define PLSR_ST_FAILS_LSB 8
// ----------------------------------------
// Reset values (freq 0.01 Hz, time 0.1 s)
// ----------------------------------------
`define PLSR_RST_SEL 8'h00
`define PLSR_RST_REGEN 2'h0
`define PLSR_RST_SUB 16'h012C
`define PLSR_RST_DEC1 16'h0032
`define PLSR_RST_DEC2 16'h270F
`define PLSR_RST_SWF 16'h1770
`define PLSR_RST_REFF 16'h1770
`define PLSR_RST_COAST 16'h270F
`define PLSR_RST_UVG 16'h0064
`define PLSR_RST_RCNT 8'h00
`define PLSR_RST_RWAIT 8'h0A
`define PLSR_RST_TERM 8'h00
// ----------------------------------------
// Codes
// ----------------------------------------
`define PLSR_UNSET 16'h270F
`define PLSR_SEL_STOP 8'h01
`define PLSR_SEL_STOP_UV 8'h0B
`define PLSR_SEL_CONT 8'h02
`define PLSR_SEL_CONT_UV 8'h0C
`define PLSR_REGEN_EXT 2'h2
`define PLSR_RCNT_MAX 8'h0A
`define PLSR_RCNT_FOUT_MIN 8'h65
`define PLSR_RCNT_FOUT_MAX 8'h6E
`define PLSR_RCNT_OFS 8'h64
`define PLSR_TF_PF 8'h2E
`define PLSR_TF_PF_N 8'h92
`define PLSR_TF_RT 8'h40
`define PLSR_TF_RT_N 8'hA4
// ----------------------------------------
// Timing
// ----------------------------------------
`define PLSR_CLK_NS 40
`define PLSR_TB_NS 100000
`define PLSR_TB_CYCLES (`PLSR_TB_NS / `PLSR_CLK_NS)
`define PLSR_TB_PER_UNIT 1000
`define PLSR_SUCC_MULT 4
`define PLSR_GAIN_SHIFT 7
`endif

/* design/plsr_pkg.sv */
package plsr_pkg;
    typedef enum logic [2:0] {PF_IDLE, PF_BYPASS, PF_RAMP, PF_STOP} plsr_pf_t;
    typedef enum logic [1:0] {RT_IDLE, RT_WAIT, RT_RUN} plsr_rt_t;
    typedef struct packed {
        logic [7:0] sel;
        logic [1:0] regen;
        logic [15:0] sub;
        logic [15:0] dec1;
        logic [15:0] dec2;
        logic [15:0] swf;
        logic [15:0] reff;
        logic [15:0] coast;
        logic [15:0] uvg;
        logic [7:0] rcnt;
        logic [7:0] rwait;
    } plsr_cfg_t;
endpackage

/* design/plsr_top.sv */
// Function
// - On undervoltage with stop selected, drop output frequency by subtracted amount first
// - Ramp with first decel time, defined from reference frequency to zero
// - Below switchover frequency use second decel time slope
// - Stop mode: power return still ramps to stop; restart needs run off then on
// - Coasting time not 9999 in stop mode: skip ramp, do auto restart
// - No start at power-up while run already asserted; controller must recycle it
// - Continuation mode: power return during ramp re-accelerates to set frequency
// - Continuation mode: power return after standstill auto restarts if coasting set
// - Selections 11/12 shorten decel on low bus, scaled by avoidance gain
// - Sensorless torque control disables avoidance; 11 acts as 1, 12 as 2
// - Decel status on during ramp, following stop, and any undervoltage
// - Decel status to terminals coded 46 high or 146 low
// - Regenerative selection 2 disables the whole power-fail decel function
// - Negative start frequency clamps to 0 Hz with DC braking, no ramp
// - No power-fail sequence while stopped or in error
// - Stop function selected suppresses undervoltage, power-fail, phase-loss trips
// - Retry count 0 off, 1-10 fault output off, 101-110 output on
// - Wait retry time then clear fault and restart; zero means 0.1 s
// - More consecutive failures than count raises excess fault and trips
// - Fault-free run over four wait times: success count up, failures cleared
// - Writing zero to success counter clears it
// - Retry status on during retry, to terminals coded 64 high or 164 low
`include "plsr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module plsr_top #(
    parameter int NF = 8,
    parameter int NTERM = 7,
    parameter int TB_CYCLES = `PLSR_TB_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic UV_DETECT,
    input wire logic BUS_LOW,
    input wire logic SVC_TORQUE,
    input wire logic DRIVE_STOPPED,
    input wire logic FORWARD_RUN_COMMAND,
    input wire logic REVERSE_RUN_COMMAND,
    input wire logic [15:0] OUT_FREQ,
    input wire logic [NF-1:0] FAULT_IN,
    output logic FREQ_OVR,
    output logic [15:0] FREQ_CMD,
    output logic DC_BRAKE,
    output logic AUTO_RESTART,
    output logic RUN_ENABLE,
    output logic PROT_SUPPRESS,
    output logic RETRY_RESET,
    output logic RETRY_EXCESS_FAULT,
    output logic FAULT_OUT,
    output logic [NTERM-1:0] TERM_OUT
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [26:0] ticks(input logic [15:0] t);
        ticks = 27'(t) * 27'(`PLSR_TB_PER_UNIT);
    endfunction

    function automatic logic term_fn(input logic [7:0] c, input logic pf, input logic rt);
        term_fn = (c == `PLSR_TF_PF & pf) | (c == `PLSR_TF_PF_N & ~pf) |
            (c == `PLSR_TF_RT & rt) | (c == `PLSR_TF_RT_N & ~rt);
    endfunction

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    logic [15:0] tb_q, tb_d;
    logic tick_q, tick_d;

    always_comb begin
        tb_d = tb_q + 16'h0001;
        tick_d = 1'b0;
        if (tb_q >= 16'(TB_CYCLES - 1)) begin
            tb_d = 16'h0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tb_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tb_q <= tb_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    plsr_pkg::plsr_cfg_t cfg_q, cfg_d;
    logic [NF-1:0] rsel_q, rsel_d;
    logic [7:0] term_q [NTERM];
    logic [7:0] term_d [NTERM];
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic wr, wr_rcnt, wr_succ0;
    logic [7:0] tidx;
    logic hit_term;
    plsr_pkg::plsr_pf_t pf_q, pf_d;
    plsr_pkg::plsr_rt_t rt_q, rt_d;
    logic [15:0] freq_q, freq_d;
    logic [7:0] fails_q, fails_d;
    logic [15:0] succ_q, succ_d;
    logic excess_q, excess_d;
    logic pfs_q, pfs_d;
    logic rtb_q;

    assign wr = PSEL & PENABLE & PWRITE & ready_q;
    assign tidx = 8'((PADDR - `PLSR_A_TERM0) >> 2);
    assign hit_term = PADDR >= `PLSR_A_TERM0 && tidx < 8'(NTERM) && PADDR[1:0] == 2'h0;
    assign wr_rcnt = wr & (PADDR == `PLSR_A_RCNT);
    assign wr_succ0 = wr & (PADDR == `PLSR_A_SUCC) & (PWDATA[15:0] == 16'h0000);

    always_comb begin
        cfg_d = cfg_q;
        rsel_d = rsel_q;
        term_d = term_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        // Zero wait: answer in the first access cycle
        ready_d = PSEL & ~PENABLE;
        if (PSEL & ~PENABLE) begin
            rdata_d = 32'h0000_0000;
            case (PADDR)
                `PLSR_A_CTRL: rdata_d = {22'h0, cfg_q.regen, cfg_q.sel};
                `PLSR_A_SUB: rdata_d = {16'h0, cfg_q.sub};
                `PLSR_A_DEC1: rdata_d = {16'h0, cfg_q.dec1};
                `PLSR_A_DEC2: rdata_d = {16'h0, cfg_q.dec2};
                `PLSR_A_SWF: rdata_d = {16'h0, cfg_q.swf};
                `PLSR_A_REFF: rdata_d = {16'h0, cfg_q.reff};
                `PLSR_A_COAST: rdata_d = {16'h0, cfg_q.coast};
                `PLSR_A_UVG: rdata_d = {16'h0, cfg_q.uvg};
                `PLSR_A_RCNT: rdata_d = {24'h0, cfg_q.rcnt};
                `PLSR_A_RWAIT: rdata_d = {24'h0, cfg_q.rwait};
                `PLSR_A_RSEL: rdata_d = 32'(rsel_q);
                `PLSR_A_SUCC: rdata_d = {16'h0, succ_q};
                `PLSR_A_STAT: rdata_d = {16'h0, fails_q, 4'h0, FREQ_OVR, excess_q, rtb_q, pfs_q};
                `PLSR_A_FREQ: rdata_d = {16'h0, freq_q};
                default: begin
                    if (hit_term) begin
                        rdata_d = {24'h0, term_q[tidx[2:0]]};
                    end else begin
                        err_d = 1'b1;
                    end
                end
            endcase
        end
        if (wr) begin
            case (PADDR)
                `PLSR_A_CTRL: begin
                    cfg_d.sel = PWDATA[7:0];
                    cfg_d.regen = PWDATA[`PLSR_CTRL_REGEN_LSB +: 2];
                end
                `PLSR_A_SUB: cfg_d.sub = PWDATA[15:0];
                `PLSR_A_DEC1: cfg_d.dec1 = PWDATA[15:0];
                `PLSR_A_DEC2: cfg_d.dec2 = PWDATA[15:0];
                `PLSR_A_SWF: cfg_d.swf = PWDATA[15:0];
                `PLSR_A_REFF: cfg_d.reff = PWDATA[15:0];
                `PLSR_A_COAST: cfg_d.coast = PWDATA[15:0];
                `PLSR_A_UVG: cfg_d.uvg = PWDATA[15:0];
                `PLSR_A_RCNT: cfg_d.rcnt = PWDATA[7:0];
                `PLSR_A_RWAIT: cfg_d.rwait = PWDATA[7:0];
                `PLSR_A_RSEL: rsel_d = PWDATA[NF-1:0];
                default: begin
                    if (hit_term) begin
                        term_d[tidx[2:0]] = PWDATA[7:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg_q <= '{`PLSR_RST_SEL, `PLSR_RST_REGEN, `PLSR_RST_SUB, `PLSR_RST_DEC1,
                `PLSR_RST_DEC2, `PLSR_RST_SWF, `PLSR_RST_REFF, `PLSR_RST_COAST,
                `PLSR_RST_UVG, `PLSR_RST_RCNT, `PLSR_RST_RWAIT};
            rsel_q <= '0;
            for (int i = 0; i < NTERM; i++) begin
                term_q[i] <= `PLSR_RST_TERM;
            end
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rsel_q <= rsel_d;
            term_q <= term_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    assign PRDATA = rdata_q;
    assign PREADY = ready_q;
    assign PSLVERR = err_q;

    // ----------------------------------------
    // Power-failure sequencer
    // ----------------------------------------
    logic [27:0] acc_q, acc_d;
    logic armed_q, armed_d;
    logic dcb_d, ar_d, ovr_d, run_en_d, sup_d;
    logic dcb_q, ar_q, ovr_q, run_en_q, sup_q;
    logic stop_m, cont_m, uv_av, func_en, coast_on, run_any, drv_err;
    logic [26:0] t1, t2, tsel, boost;
    logic [31:0] prod;

    assign run_any = FORWARD_RUN_COMMAND | REVERSE_RUN_COMMAND;
    // Torque control folds 11/12 onto 1/2
    assign stop_m = cfg_q.sel == `PLSR_SEL_STOP || cfg_q.sel == `PLSR_SEL_STOP_UV;
    assign cont_m = cfg_q.sel == `PLSR_SEL_CONT || cfg_q.sel == `PLSR_SEL_CONT_UV;
    assign uv_av = (cfg_q.sel == `PLSR_SEL_STOP_UV || cfg_q.sel == `PLSR_SEL_CONT_UV) & ~SVC_TORQUE;
    assign func_en = (stop_m | cont_m) & (cfg_q.regen != `PLSR_REGEN_EXT);
    assign coast_on = cfg_q.coast != `PLSR_UNSET;
    assign drv_err = (|FAULT_IN) | excess_q;
    assign t1 = ticks(cfg_q.dec1);
    assign t2 = (cfg_q.dec2 == `PLSR_UNSET) ? t1 : ticks(cfg_q.dec2);
    assign tsel = (freq_q < cfg_q.swf) ? t2 : t1;
    assign prod = cfg_q.reff * cfg_q.uvg;
    // Low bus steepens the slope in proportion to the gain
    assign boost = (uv_av & BUS_LOW) ? 27'(prod >> `PLSR_GAIN_SHIFT) : 27'h0;

    always_comb begin
        pf_d = pf_q;
        freq_d = freq_q;
        acc_d = acc_q;
        dcb_d = 1'b0;
        ar_d = 1'b0;
        // Power-up with run held stays locked until run drops
        armed_d = armed_q | ~run_any;
        case (pf_q)
            plsr_pkg::PF_IDLE: begin
                if (UV_DETECT & func_en & ~DRIVE_STOPPED & ~drv_err) begin
                    acc_d = 28'h0;
                    if (stop_m & coast_on) begin
                        pf_d = plsr_pkg::PF_BYPASS;
                    end else if (OUT_FREQ >= cfg_q.sub) begin
                        freq_d = OUT_FREQ - cfg_q.sub;
                        pf_d = plsr_pkg::PF_RAMP;
                    end else begin
                        freq_d = 16'h0000;
                        dcb_d = 1'b1;
                        pf_d = plsr_pkg::PF_STOP;
                    end
                end
            end
            plsr_pkg::PF_BYPASS: begin
                if (~UV_DETECT) begin
                    ar_d = 1'b1;
                    pf_d = plsr_pkg::PF_IDLE;
                end
            end
            plsr_pkg::PF_RAMP: begin
                if (~UV_DETECT & cont_m) begin
                    pf_d = plsr_pkg::PF_IDLE;
                end else if (freq_q == 16'h0000 || tsel == 27'h0) begin
                    freq_d = 16'h0000;
                    pf_d = plsr_pkg::PF_STOP;
                end else if (tick_q) begin
                    // One step per tick; slopes faster than that are capped
                    acc_d = acc_q + 28'(cfg_q.reff) + 28'(boost);
                    if (acc_d >= 28'(tsel)) begin
                        acc_d = acc_d - 28'(tsel);
                        freq_d = freq_q - 16'h0001;
                    end
                end
            end
            plsr_pkg::PF_STOP: begin
                if (~UV_DETECT & cont_m & coast_on) begin
                    ar_d = 1'b1;
                    pf_d = plsr_pkg::PF_IDLE;
                end else if (~UV_DETECT & ~run_any) begin
                    pf_d = plsr_pkg::PF_IDLE;
                end
            end
            default: pf_d = plsr_pkg::PF_IDLE;
        endcase
        if (pf_d == plsr_pkg::PF_STOP) begin
            armed_d = 1'b0;
        end
        ovr_d = pf_d == plsr_pkg::PF_RAMP || pf_d == plsr_pkg::PF_STOP;
        run_en_d = armed_d & (pf_d != plsr_pkg::PF_STOP);
        pfs_d = ovr_d | UV_DETECT;
        sup_d = func_en;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pf_q <= plsr_pkg::PF_IDLE;
            freq_q <= 16'h0000;
            acc_q <= 28'h0;
            armed_q <= 1'b0;
            dcb_q <= 1'b0;
            ar_q <= 1'b0;
            ovr_q <= 1'b0;
            run_en_q <= 1'b0;
            pfs_q <= 1'b0;
            sup_q <= 1'b0;
        end else begin
            pf_q <= pf_d;
            freq_q <= freq_d;
            acc_q <= acc_d;
            armed_q <= armed_d;
            dcb_q <= dcb_d;
            ar_q <= ar_d;
            ovr_q <= ovr_d;
            run_en_q <= run_en_d;
            pfs_q <= pfs_d;
            sup_q <= sup_d;
        end
    end

    assign FREQ_OVR = ovr_q;
    assign FREQ_CMD = freq_q;
    assign DC_BRAKE = dcb_q;
    assign AUTO_RESTART = ar_q;
    assign RUN_ENABLE = run_en_q;
    assign PROT_SUPPRESS = sup_q;

    // ----------------------------------------
    // Retry controller
    // ----------------------------------------
    logic [29:0] cnt_q, cnt_d;
    logic rres_d, rres_q, fout_d, fout_q, rtb_d;
    logic [7:0] nmax;
    logic fhit, fout_mode;
    logic [26:0] wait_t;

    assign fout_mode = cfg_q.rcnt >= `PLSR_RCNT_FOUT_MIN && cfg_q.rcnt <= `PLSR_RCNT_FOUT_MAX;
    assign nmax = fout_mode ? cfg_q.rcnt - `PLSR_RCNT_OFS :
        (cfg_q.rcnt <= `PLSR_RCNT_MAX ? cfg_q.rcnt : 8'h00);
    assign wait_t = ticks(cfg_q.rwait == 8'h00 ? 16'h0001 : {8'h00, cfg_q.rwait});
    assign fhit = |(FAULT_IN & rsel_q);

    always_comb begin
        rt_d = rt_q;
        cnt_d = cnt_q;
        fails_d = fails_q;
        succ_d = wr_succ0 ? 16'h0000 : succ_q;
        excess_d = excess_q & ~wr_rcnt;
        rres_d = 1'b0;
        case (rt_q)
            plsr_pkg::RT_IDLE, plsr_pkg::RT_RUN: begin
                // The stale fault is ignored until the first tick after restart
                if (fhit & ~excess_q & (rt_q == plsr_pkg::RT_IDLE || cnt_q != 30'h0)) begin
                    cnt_d = 30'h0;
                    if (nmax == 8'h00) begin
                        rt_d = plsr_pkg::RT_IDLE;
                    end else if (fails_q >= nmax) begin
                        excess_d = 1'b1;
                        rt_d = plsr_pkg::RT_IDLE;
                    end else begin
                        fails_d = fails_q + 8'h01;
                        rt_d = plsr_pkg::RT_WAIT;
                    end
                end else if (rt_q == plsr_pkg::RT_RUN && tick_q) begin
                    cnt_d = cnt_q + 30'h1;
                    if (cnt_d > 30'(wait_t) * 30'(`PLSR_SUCC_MULT)) begin
                        succ_d = succ_d + 16'h0001;
                        fails_d = 8'h00;
                        rt_d = plsr_pkg::RT_IDLE;
                    end
                end
            end
            plsr_pkg::RT_WAIT: begin
                if (tick_q) begin
                    cnt_d = cnt_q + 30'h1;
                    if (cnt_d >= 30'(wait_t)) begin
                        rres_d = 1'b1;
                        cnt_d = 30'h0;
                        rt_d = plsr_pkg::RT_RUN;
                    end
                end
            end
            default: rt_d = plsr_pkg::RT_IDLE;
        endcase
        if (wr_rcnt) begin
            fails_d = 8'h00;
        end
        rtb_d = rt_d != plsr_pkg::RT_IDLE;
        fout_d = excess_d | ((|FAULT_IN) & (~rtb_d | fout_mode));
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rt_q <= plsr_pkg::RT_IDLE;
            cnt_q <= 30'h0;
            fails_q <= 8'h00;
            succ_q <= 16'h0000;
            excess_q <= 1'b0;
            rres_q <= 1'b0;
            rtb_q <= 1'b0;
            fout_q <= 1'b0;
        end else begin
            rt_q <= rt_d;
            cnt_q <= cnt_d;
            fails_q <= fails_d;
            succ_q <= succ_d;
            excess_q <= excess_d;
            rres_q <= rres_d;
            rtb_q <= rtb_d;
            fout_q <= fout_d;
        end
    end

    assign RETRY_RESET = rres_q;
    assign RETRY_EXCESS_FAULT = excess_q;
    assign FAULT_OUT = fout_q;

    // ----------------------------------------
    // Output terminals
    // ----------------------------------------
    logic [NTERM-1:0] tout_q, tout_d;

    always_comb begin
        for (int i = 0; i < NTERM; i++) begin
            tout_d[i] = term_fn(term_q[i], pfs_d, rtb_d);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tout_q <= '0;
        end else begin
            tout_q <= tout_d;
        end
    end

    assign TERM_OUT = tout_q;
endmodule
`default_nettype wire

/* verification/plsr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module plsr_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic UV_DETECT,
    input wire logic DRIVE_STOPPED,
    input wire logic FORWARD_RUN_COMMAND,
    input wire logic REVERSE_RUN_COMMAND,
    input wire logic FREQ_OVR,
    input wire logic [15:0] FREQ_CMD,
    input wire logic DC_BRAKE,
    input wire logic RUN_ENABLE,
    input wire logic RETRY_RESET
);
    // ---
    // Checks
    // ---
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_brake;
        DC_BRAKE && FREQ_CMD == 16'h0000;
    endsequence
    a_apb_answer: assert property (s_setup |=> PREADY) else $error("no ready");
    a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready too long");
    a_slverr_ready: assert property (PSLVERR |-> PREADY) else $error("slverr alone");
    a_brake_zero: assert property (DC_BRAKE |-> s_brake ##1 !DC_BRAKE)
        else $error("brake pulse bad");
    a_brake_cause: assert property (DC_BRAKE |-> $past(UV_DETECT)) else $error("brake no cause");
    a_ramp_down: assert property (FREQ_OVR && $past(FREQ_OVR) |-> FREQ_CMD <= $past(FREQ_CMD))
        else $error("ramp rose");
    a_no_start_idle: assert property ($rose(FREQ_OVR) |-> !$past(DRIVE_STOPPED) && $past(UV_DETECT))
        else $error("ramp while stopped");
    a_retry_pulse: assert property (RETRY_RESET |=> !RETRY_RESET) else $error("retry pulse long");
    a_run_after_off: assert property ($rose(RUN_ENABLE) |->
        !$past(FORWARD_RUN_COMMAND) && !$past(REVERSE_RUN_COMMAND)) else $error("start with run held");
endmodule
bind plsr_top plsr_checker u_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .UV_DETECT(UV_DETECT), .DRIVE_STOPPED(DRIVE_STOPPED),
    .FORWARD_RUN_COMMAND(FORWARD_RUN_COMMAND), .REVERSE_RUN_COMMAND(REVERSE_RUN_COMMAND),
    .FREQ_OVR(FREQ_OVR), .FREQ_CMD(FREQ_CMD), .DC_BRAKE(DC_BRAKE), .RUN_ENABLE(RUN_ENABLE),
    .RETRY_RESET(RETRY_RESET));
`default_nettype wire

/* verification/plsr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module plsr_ctrl_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic recycle,
    output logic fwd_run,
    output logic rev_run
);
    // ---
    // Run command
    // ---
    logic [1:0] off_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_q <= 2'h0;
        end else if (recycle) begin
            off_q <= 2'h3;
        end else if (off_q != 2'h0) begin
            off_q <= off_q - 2'h1;
        end
    end
    // Held on through power-up; a restart drops it for three cycles
    assign fwd_run = (off_q == 2'h0);
    assign rev_run = 1'h0;
endmodule
`default_nettype wire

/* verification/plsr_top_bench.sv */
`timescale 1ns/1ps
`include "plsr_cfg.svh"
`default_nettype none
module plsr_top_bench;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, uv = 0, stp = 0, rcy = 0, bl = 0, sv = 0;
    logic [7:0] pa = 0, fin = 0;
    logic [15:0] of = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic rdy, err, ovr, dcb, ars, ren, sup, rrs, exc, fo, fr, rr, e;
    logic [15:0] fc;
    logic [6:0] term;
    int n_errors = 0, checks_done = 0, n;
    initial forever #20 clk = ~clk;
    plsr_ctrl_model MDL (.clk(clk), .rst(rst), .recycle(rcy), .fwd_run(fr), .rev_run(rr));
    plsr_top #(.TB_CYCLES(4)) DUT (.CLK(clk), .RST(rst), .PADDR(pa), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .UV_DETECT(uv),
        .BUS_LOW(bl), .SVC_TORQUE(sv), .DRIVE_STOPPED(stp), .FORWARD_RUN_COMMAND(fr),
        .REVERSE_RUN_COMMAND(rr), .OUT_FREQ(of), .FAULT_IN(fin), .FREQ_OVR(ovr), .FREQ_CMD(fc),
        .DC_BRAKE(dcb), .AUTO_RESTART(ars), .RUN_ENABLE(ren), .PROT_SUPPRESS(sup), .RETRY_RESET(rrs),
        .RETRY_EXCESS_FAULT(exc), .FAULT_OUT(fo), .TERM_OUT(term));
    // ---
    // Tasks
    // ---
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // Request held until the edge that samples ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        pa <= a;
        pwr <= w;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        for (k = 0; k < 9; k++) begin
            @(posedge clk);
            if (rdy === 1'h1) break;
        end
        rd = prd;
        e = err;
        psel <= 0;
        pen <= 0;
        if (k == 9) begin
            n_errors++;
            conclude();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(s, rd, x);
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return fc == 16'h0000;
            1: return dcb;
            2: return ars;
            3: return rrs;
            4: return !term[2];
            5: return exc;
            default: return ren;
        endcase
    endfunction
    task automatic wait_hi(input int k, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge clk);
            if (probe(k) === 1'h1) break;
        end
        if (n > lim) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic recyc;
        rcy <= 1;
        @(posedge clk);
        rcy <= 0;
    endtask
    // ---
    // Sequence
    // ---
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        chk("ren_held", ren, 1'h0);
        recyc();
        wait_hi(6, 20);
        rchk("ctrl", `PLSR_A_CTRL, 32'h0);
        rchk("sub", `PLSR_A_SUB, 32'h12C);
        rchk("coast", `PLSR_A_COAST, 32'h270F);
        rchk("rwait", `PLSR_A_RWAIT, 32'hA);
        rchk("hole", 8'h4C, 32'h0);
        chk("hole_err", e, 1'h1);
        wr(`PLSR_A_TERM0, 32'h2E);
        wr(`PLSR_A_TERM0 + 8'h04, 32'h92);
        wr(`PLSR_A_TERM0 + 8'h08, 32'h40);
        wr(`PLSR_A_SUB, 32'h100);
        wr(`PLSR_A_CTRL, 32'h1);
        of <= 16'h0110;
        uv <= 1;
        repeat (2) @(posedge clk);
        chk("ovr", ovr, 1'h1);
        chk("fcmd", fc, 16'h0010);
        chk("t46", term[0], 1'h1);
        chk("t146", term[1], 1'h0);
        chk("supp", sup, 1'h1);
        uv <= 0;
        wait_hi(0, 2000);
        repeat (4) @(posedge clk);
        chk("hold", ovr, 1'h1);
        chk("hold_ren", ren, 1'h0);
        chk("hold_t46", term[0], 1'h1);
        recyc();
        wait_hi(6, 20);
        chk("free", ovr, 1'h0);
        wr(`PLSR_A_CTRL, 32'h201);
        uv <= 1;
        repeat (3) @(posedge clk);
        chk("regen", ovr, 1'h0);
        uv <= 0;
        stp <= 1;
        wr(`PLSR_A_CTRL, 32'h1);
        uv <= 1;
        repeat (3) @(posedge clk);
        chk("stopped", ovr, 1'h0);
        chk("uv_t46", term[0], 1'h1);
        uv <= 0;
        stp <= 0;
        wr(`PLSR_A_CTRL, 32'hC);
        of <= 16'h0200;
        bl <= 1;
        sv <= 1;
        uv <= 1;
        // 11 or 12 ticks: one step plain, two with avoidance
        repeat (48) @(posedge clk);
        chk("no_avoid", fc, 16'h00FF);
        uv <= 0;
        sv <= 0;
        repeat (3) @(posedge clk);
        chk("reaccel", ovr, 1'h0);
        uv <= 1;
        repeat (48) @(posedge clk);
        chk("avoid", fc, 16'h00FE);
        uv <= 0;
        bl <= 0;
        repeat (3) @(posedge clk);
        wr(`PLSR_A_COAST, 32'h64);
        of <= 16'h0050;
        uv <= 1;
        wait_hi(1, 4);
        chk("dc_f0", fc, 16'h0);
        uv <= 0;
        wait_hi(2, 8);
        wr(`PLSR_A_CTRL, 32'h1);
        uv <= 1;
        repeat (3) @(posedge clk);
        chk("coast_on", ovr, 1'h0);
        uv <= 0;
        wait_hi(2, 4);
        wr(`PLSR_A_RSEL, 32'h1);
        wr(`PLSR_A_RCNT, 32'h2);
        wr(`PLSR_A_RWAIT, 32'h0);
        fin <= 8'h01;
        wait_hi(3, 5000);
        chk("wait_len", n > 3990 && n < 4010, 1'h1);
        chk("t64", term[2], 1'h1);
        chk("fo_off", fo, 1'h0);
        fin <= 8'h00;
        wait_hi(4, 17000);
        chk("succ_len", n > 15990, 1'h1);
        rchk("succ", `PLSR_A_SUCC, 32'h1);
        wr(`PLSR_A_SUCC, 32'h0);
        rchk("succ_clr", `PLSR_A_SUCC, 32'h0);
        wr(`PLSR_A_RCNT, 32'h65);
        fin <= 8'h01;
        wait_hi(3, 5000);
        chk("fo_on", fo, 1'h1);
        fin <= 8'h00;
        repeat (40) @(posedge clk);
        fin <= 8'h01;
        wait_hi(5, 10);
        conclude();
    end
endmodule
`default_nettype wire
